//--- plsr_pkg.sv
// Purpose: constants and carriers for the status/receive port
// Assumes: 100 MHz aclk, axi4-lite register access
// Notes:   codes on the two control lines and the eight data lines
package plsr_pkg;

    localparam logic [1:0] CTL_IDLE    = 2'h0;
    localparam logic [1:0] CTL_STATUS  = 2'h1;
    localparam logic [1:0] CTL_RECEIVE = 2'h2;

    localparam logic [7:0] DATA_ON     = 8'hff;
    localparam logic [7:0] CODE_LOW    = 8'h00;
    localparam logic [7:0] CODE_MID    = 8'h40;
    localparam logic [7:0] CODE_HIGH   = 8'h50;

    localparam logic [3:0] PAIRS_FLAGS = 4'h2;
    localparam logic [3:0] PAIRS_FULL  = 4'h8;
    localparam logic [3:0] PAIR_LAST   = 4'h7;

    localparam logic [3:0] NODE_ID_REG_ADDR = 4'h0;

    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_REGREQ  = 4'h4;
    localparam logic [3:0] OFS_STATUS  = 4'h8;
    localparam logic [3:0] OFS_RXCOUNT = 4'hc;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SPEED_LOW,
        SPEED_MID,
        SPEED_HIGH,
        SPEED_RSVD
    } plsr_speed_e;

    // status flag events from the serial-bus core, one-cycle pulses
    typedef struct packed {
        logic intr;
        logic bus_reset;
        logic sub_gap;
        logic arb_gap;
    } plsr_evt_s;

    // receive stream from the serial-bus core
    typedef struct packed {
        logic        prefix;
        logic        speed_vld;
        plsr_speed_e speed;
        logic        dvalid;
        logic [7:0]  data;
        logic        data_end;
    } plsr_rx_s;

    // register report request: address and contents
    typedef struct packed {
        logic       req;
        logic [3:0] addr;
        logic [7:0] data;
    } plsr_reg_s;

endpackage

//--- plsr_port.sv
// Purpose: phy side of the link interface, status transfer and receive
// Assumes: serial-bus core inputs are synchronous to aclk
// Notes:   control and data lines are driven by this block at all times
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps

module plsr_port #(
    parameter int CNT_W = 16
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [3:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [3:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire plsr_pkg::plsr_evt_s evt,
    input  wire plsr_pkg::plsr_rx_s  rx,
    input  wire plsr_pkg::plsr_reg_s reg_read,
    input  wire logic                selfid_done,
    input  wire logic [7:0]          node_id_reg,
    output logic [1:0]               interface_control_lines,
    output logic [7:0]               link_data
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STATUS,
        ST_RX_ON,
        ST_RX_DATA
    } plsr_state_e;

    function automatic logic [7:0] speed_code(input plsr_pkg::plsr_speed_e s);
        unique case (s)
            plsr_pkg::SPEED_LOW:  speed_code = plsr_pkg::CODE_LOW;
            plsr_pkg::SPEED_MID:  speed_code = plsr_pkg::CODE_MID;
            plsr_pkg::SPEED_HIGH: speed_code = plsr_pkg::CODE_HIGH;
            plsr_pkg::SPEED_RSVD: speed_code = plsr_pkg::CODE_HIGH;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register bus
    logic [31:0]      ctrl_r;
    logic             aw_got_r;
    logic             w_got_r;
    logic [3:0]       awaddr_r;
    logic [31:0]      wdata_r;
    logic [3:0]       wstrb_r;
    logic [CNT_W-1:0] rx_count_r;
    logic [3:0]       flags_r;
    logic             reg_pend_r;
    logic [3:0]       reg_addr_r;
    logic [7:0]       reg_data_r;
    plsr_state_e      state_r;

    wire        aw_take   = s_axi_awvalid && s_axi_awready;
    wire        w_take    = s_axi_wvalid && s_axi_wready;
    wire        aw_have   = aw_got_r || aw_take;
    wire        w_have    = w_got_r || w_take;
    wire        wr_fire   = aw_have && w_have && !s_axi_bvalid;
    wire [3:0]  wr_addr   = aw_got_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wr_data   = w_got_r ? wdata_r : s_axi_wdata;
    wire [3:0]  wr_strb   = w_got_r ? wstrb_r : s_axi_wstrb;
    wire        wr_ctrl   = wr_fire && wr_addr == plsr_pkg::OFS_CTRL;
    wire        wr_regreq = wr_fire && wr_addr == plsr_pkg::OFS_REGREQ
                            && wr_strb[0] && wr_strb[1];
    wire        wr_known  = wr_addr == plsr_pkg::OFS_CTRL
                            || wr_addr == plsr_pkg::OFS_REGREQ;
    wire        rd_take   = s_axi_arvalid && s_axi_arready;
    wire [31:0] status_word = {25'h0, state_r, reg_pend_r, flags_r};
    wire        rd_known  = s_axi_araddr == plsr_pkg::OFS_CTRL
                            || s_axi_araddr == plsr_pkg::OFS_STATUS
                            || s_axi_araddr == plsr_pkg::OFS_RXCOUNT;
    wire [31:0] rd_mux    =
        s_axi_araddr == plsr_pkg::OFS_CTRL    ? ctrl_r :
        s_axi_araddr == plsr_pkg::OFS_STATUS  ? status_word :
        s_axi_araddr == plsr_pkg::OFS_RXCOUNT ?
            {{(32-CNT_W){1'b0}}, rx_count_r} : 32'h0;

    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            awaddr_r     <= 4'h0;
            wdata_r      <= 32'h0;
            wstrb_r      <= 4'h0;
            ctrl_r       <= plsr_pkg::CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= plsr_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= plsr_pkg::RESP_OKAY;
        end else begin
            aw_got_r <= aw_have && !wr_fire;
            w_got_r  <= w_have && !wr_fire;
            if (aw_take) awaddr_r <= s_axi_awaddr;
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_ctrl && wr_strb[0]) ctrl_r[7:0] <= wr_data[7:0];
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? plsr_pkg::RESP_OKAY
                                         : plsr_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_known ? plsr_pkg::RESP_OKAY
                                         : plsr_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pending status and register report
    logic [3:0]  pair_r;
    logic        full_r;
    logic [15:0] word_r;
    logic [1:0]  ctl_r;
    logic [7:0]  data_r;

    wire        stat_en    = ctrl_r[0];
    wire        in_status  = state_r == ST_STATUS;
    wire        in_idle    = state_r == ST_IDLE;
    wire        in_rx_on   = state_r == ST_RX_ON;
    wire        in_rx_data = state_r == ST_RX_DATA;
    // a transfer only opens after a cycle of idle already on the lines
    wire        stat_go    = in_idle && !rx.prefix && stat_en
                             && ctl_r == plsr_pkg::CTL_IDLE
                             && (flags_r != 4'h0 || reg_pend_r);
    wire [15:0] live_word  = {reg_data_r, reg_addr_r, flags_r};
    wire        stat_cont  = in_status && !rx.prefix
                             && pair_r != (full_r ? plsr_pkg::PAIRS_FULL
                                                  : plsr_pkg::PAIRS_FLAGS);
    wire [15:0] drv_word   = stat_go ? live_word : word_r;
    wire [3:0]  drv_pair   = stat_go ? 4'h0 : pair_r;
    wire [1:0]  drv_bits   = drv_word[{drv_pair[2:0], 1'b0} +: 2];
    wire        drive_st   = stat_go || stat_cont;
    // flags leave the pending set as their pair goes out
    wire [3:0]  flag_clr   = {4{drive_st}} & {
                                 {2{drv_pair == 4'h1}} & word_r[3:2],
                                 {2{drv_pair == 4'h0}} & drv_word[1:0]};
    wire        reg_done   = stat_cont && full_r
                             && pair_r == plsr_pkg::PAIR_LAST;
    wire [3:0]  flag_set   = {evt.intr, evt.bus_reset,
                              evt.sub_gap, evt.arb_gap};
    wire        new_reg    = selfid_done || reg_read.req || wr_regreq;
    wire [3:0]  new_addr   = selfid_done ? plsr_pkg::NODE_ID_REG_ADDR :
                             reg_read.req ? reg_read.addr : wr_data[3:0];
    wire [7:0]  new_data   = selfid_done ? node_id_reg :
                             reg_read.req ? reg_read.data : wr_data[15:8];
    wire        reg_load   = new_reg && (!reg_pend_r || reg_done);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r    <= 4'h0;
            reg_pend_r <= 1'b0;
            reg_addr_r <= 4'h0;
            reg_data_r <= 8'h0;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
            if (reg_load) begin
                reg_pend_r <= 1'b1;
                reg_addr_r <= new_addr;
                reg_data_r <= new_data;
            end else if (reg_done) begin
                reg_pend_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interface line sequencer
    plsr_state_e state_nxt;
    logic [1:0]  ctl_nxt;
    logic [7:0]  data_nxt;

    always_comb begin
        state_nxt = state_r;
        ctl_nxt   = plsr_pkg::CTL_IDLE;
        data_nxt  = 8'h00;
        if (rx.prefix && (in_idle || in_status)) begin
            state_nxt = ST_RX_ON;
            ctl_nxt   = plsr_pkg::CTL_RECEIVE;
            data_nxt  = plsr_pkg::DATA_ON;
        end else if (drive_st) begin
            state_nxt = ST_STATUS;
            ctl_nxt   = plsr_pkg::CTL_STATUS;
            data_nxt  = {6'h00, drv_bits[1], drv_bits[0]};
        end else if (in_status) begin
            state_nxt = ST_IDLE;
        end else if (in_rx_on) begin
            if (rx.data_end) begin
                state_nxt = ST_IDLE;
            end else if (rx.speed_vld) begin
                state_nxt = ST_RX_DATA;
                ctl_nxt   = plsr_pkg::CTL_RECEIVE;
                data_nxt  = speed_code(rx.speed);
            end else begin
                ctl_nxt   = plsr_pkg::CTL_RECEIVE;
                data_nxt  = plsr_pkg::DATA_ON;
            end
        end else if (in_rx_data) begin
            if (rx.data_end) begin
                state_nxt = ST_IDLE;
            end else begin
                ctl_nxt   = plsr_pkg::CTL_RECEIVE;
                data_nxt  = rx.dvalid ? rx.data : data_r;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r    <= ST_IDLE;
            ctl_r      <= plsr_pkg::CTL_IDLE;
            data_r     <= 8'h00;
            pair_r     <= 4'h0;
            full_r     <= 1'b0;
            word_r     <= 16'h0;
            rx_count_r <= '0;
        end else begin
            state_r <= state_nxt;
            ctl_r   <= ctl_nxt;
            data_r  <= data_nxt;
            if (stat_go) begin
                word_r <= live_word;
                full_r <= reg_pend_r;
                pair_r <= 4'h1;
            end else if (stat_cont) begin
                pair_r <= pair_r + 4'h1;
            end
            if ((in_rx_on || in_rx_data) && rx.data_end)
                rx_count_r <= rx_count_r + 1'b1;
        end
    end

    assign interface_control_lines = ctl_r;
    assign link_data               = data_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_status_start: assert property (@(posedge aclk) disable iff (!aresetn)
        stat_go |=> ctl_r == plsr_pkg::CTL_STATUS
                    && $past(ctl_r) == plsr_pkg::CTL_IDLE)
        else $error("status started without idle before");
    chk_status_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctl_r == plsr_pkg::CTL_STATUS && state_r == ST_IDLE)
        |=> ctl_r != plsr_pkg::CTL_STATUS)
        else $error("back to back status transfers");
    chk_flags_len: assert property (@(posedge aclk) disable iff (!aresetn)
        (stat_go && !reg_pend_r) ##1 (!rx.prefix)[*2]
        |-> ctl_r == plsr_pkg::CTL_STATUS
            && $past(ctl_r) == plsr_pkg::CTL_STATUS ##1
            ctl_r == plsr_pkg::CTL_IDLE)
        else $error("flag transfer not two cycles");
    chk_full_len: assert property (@(posedge aclk) disable iff (!aresetn)
        (stat_go && reg_pend_r) ##1 (!rx.prefix)[*8]
        |-> ctl_r == plsr_pkg::CTL_STATUS
            && $past(ctl_r) == plsr_pkg::CTL_STATUS ##1
            ctl_r == plsr_pkg::CTL_IDLE)
        else $error("register transfer not eight cycles");
    chk_rx_dataon: assert property (@(posedge aclk) disable iff (!aresetn)
        (rx.prefix && (in_idle || in_status)) |=>
        ctl_r == plsr_pkg::CTL_RECEIVE && data_r == plsr_pkg::DATA_ON)
        else $error("receive start without data-on");
    chk_rx_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(ctl_r) == plsr_pkg::CTL_RECEIVE
         && ctl_r != plsr_pkg::CTL_RECEIVE)
        |-> ctl_r == plsr_pkg::CTL_IDLE)
        else $error("receive not followed by idle");
    chk_speed_after_on: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ctl_r == plsr_pkg::CTL_RECEIVE && in_rx_data
         && $past(state_r) == ST_RX_ON)
        |-> $past(data_r) == plsr_pkg::DATA_ON)
        else $error("speed code without prior data-on");
    chk_reg_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_status && full_r && rx.prefix && pair_r <= plsr_pkg::PAIR_LAST)
        |=> reg_pend_r)
        else $error("interrupted register report dropped");
    chk_flag_sent: assert property (@(posedge aclk) disable iff (!aresetn)
        (stat_go && flags_r[0] && !evt.arb_gap) |=> !flags_r[0])
        else $error("driven flag left pending");
    cov_flags: cover property (@(posedge aclk) disable iff (!aresetn)
        stat_go && !reg_pend_r);
    cov_full: cover property (@(posedge aclk) disable iff (!aresetn)
        reg_done);
    cov_abort: cover property (@(posedge aclk) disable iff (!aresetn)
        in_status && rx.prefix);
    cov_null: cover property (@(posedge aclk) disable iff (!aresetn)
        in_rx_on && rx.data_end);

endmodule // plsr_port

//--- plsr_link_model.sv
// Purpose: passive link-side model watching the status/receive lines
// Assumes: lines sampled on rising aclk, driven by the port
// Notes:   keeps last status word and last packet summary for the bench
`timescale 1ns/1ps

module plsr_link_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [1:0] ctl,
    input  wire logic [7:0] d
);
    logic [1:0]  prev;
    logic [15:0] acc;
    logic [15:0] st_word;
    logic [7:0]  rx_code;
    logic [7:0]  rx_last;
    logic        got_code;
    int          pairs;
    int          st_pairs;
    int          st_cnt;
    int          rx_cnt;
    int          rx_nb;
    int          rx_don;
    int          viol;

    always @(posedge aclk) begin
        if (!aresetn) begin
            prev = plsr_pkg::CTL_IDLE;
            acc = '0;
            pairs = 0;
            st_cnt = 0;
            rx_cnt = 0;
            viol = 0;
            got_code = 1'b0;
        end else begin
            if (ctl == plsr_pkg::CTL_STATUS) begin
                if (prev == plsr_pkg::CTL_RECEIVE) viol++;
                if (pairs < 8) acc[2*pairs +: 2] = d[1:0];
                else viol++;
                pairs++;
            end else if (prev == plsr_pkg::CTL_STATUS) begin
                st_word = acc;
                st_pairs = pairs;
                st_cnt++;
                acc = '0;
                pairs = 0;
            end
            if (ctl == plsr_pkg::CTL_RECEIVE) begin
                if (prev != plsr_pkg::CTL_RECEIVE) begin
                    rx_nb = 0;
                    rx_don = 0;
                    got_code = 1'b0;
                end
                // speed is the first cycle that is not data-on
                if (!got_code && d == plsr_pkg::DATA_ON) rx_don++;
                else if (!got_code) begin
                    rx_code = d;
                    got_code = 1'b1;
                end else begin
                    rx_nb++;
                    rx_last = d;
                end
            end else if (prev == plsr_pkg::CTL_RECEIVE) begin
                rx_cnt++;
                if (ctl != plsr_pkg::CTL_IDLE) viol++;
            end
            if (ctl == 2'h3) viol++;
            prev = ctl;
        end
    end
endmodule // plsr_link_model

//--- tb_top.sv
// Purpose: self-checking bench for the status/receive port
// Assumes: 100 MHz aclk, axi4-lite master driven on rising edges
// Notes:   link-side model records transfers seen on the lines
`timescale 1ns/1ps

module tb_top;
    logic                aclk = 1'b0;
    logic                aresetn = 1'b0;
    logic [3:0]          awaddr;
    logic [3:0]          araddr;
    logic [3:0]          wstrb;
    logic [31:0]         wdata;
    logic                awvalid;
    logic                wvalid;
    logic                bready;
    logic                arvalid;
    logic                rready;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic                arready;
    logic                rvalid;
    logic [1:0]          bresp;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic [1:0]          ctl;
    logic [7:0]          ldat;
    logic [7:0]          node_id_reg;
    logic                selfid_done;
    plsr_pkg::plsr_evt_s evt;
    plsr_pkg::plsr_rx_s  rx;
    plsr_pkg::plsr_reg_s reg_read;
    logic [1:0]          resp;
    logic [31:0]         rd;
    logic [7:0]          code_tab [4];
    int                  fails = 0;
    int                  n_compared = 0;
    int                  cyc = 0;
    int                  c0;
    logic                aw_ok;
    logic                w_ok;
    logic                b_ok;
    logic                ar_ok;
    logic                r_ok;

    always #5 aclk = ~aclk;

    plsr_port #(.CNT_W(16)) plsr_port_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt(evt), .rx(rx),
        .reg_read(reg_read), .selfid_done(selfid_done),
        .node_id_reg(node_id_reg), .interface_control_lines(ctl),
        .link_data(ldat)
    );

    plsr_link_model lnk (.aclk(aclk), .aresetn(aresetn), .ctl(ctl), .d(ldat));

    ////////////////////////////////////////////////////////////////////////
    task test_done;
        if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100) begin
            // settled values are what the next rising edge samples
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (b_ok) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task axr(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100) begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            rd = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
            if (r_ok) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task expect_st(input int c, input logic [15:0] w, input int np);
        repeat (40) begin
            @(negedge aclk);
            if (lnk.st_cnt != c) break;
        end
        cmp(lnk.st_cnt, c + 1);
        cmp(lnk.st_word, w);
        cmp(lnk.st_pairs, np);
    endtask

    task pulse(input logic [3:0] e, input plsr_pkg::plsr_reg_s r);
        @(posedge aclk);
        evt <= e;
        reg_read <= r;
        @(posedge aclk);
        evt <= '0;
        reg_read <= '0;
    endtask

    task do_rx(input int sp, input int n);
        int c;
        c = lnk.rx_cnt;
        @(posedge aclk);
        rx.prefix <= 1'b1;
        @(posedge aclk);
        rx.prefix <= 1'b0;
        rx.speed_vld <= (n > 0);
        rx.speed <= plsr_pkg::plsr_speed_e'(sp);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            rx.speed_vld <= 1'b0;
            rx.dvalid <= 1'b1;
            rx.data <= 8'(8'h20 + i);
        end
        @(posedge aclk);
        rx.speed_vld <= 1'b0;
        rx.dvalid <= 1'b0;
        rx.data_end <= 1'b1;
        @(posedge aclk);
        rx.data_end <= 1'b0;
        repeat (3) @(negedge aclk);
        cmp(lnk.rx_cnt, c + 1);
        cmp(lnk.rx_don >= 1, 1);
        cmp(lnk.got_code, n > 0);
        cmp(lnk.rx_nb, n);
        if (n > 0) cmp(lnk.rx_code, code_tab[sp]);
        if (n > 0) cmp(lnk.rx_last, 8'h1f + n);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        cmp(ctl, plsr_pkg::CTL_IDLE);
        axr(plsr_pkg::OFS_CTRL);
        cmp(rd, plsr_pkg::CTRL_RESET);
        axw(plsr_pkg::OFS_STATUS, 32'h0000_000f);
        cmp(resp, plsr_pkg::RESP_SLVERR);
        axr(plsr_pkg::OFS_RXCOUNT);
        cmp(rd, 32'h0);
    endtask

    task t_flags;
        for (int i = 0; i < 4; i++) begin
            c0 = lnk.st_cnt;
            pulse(4'(1 << i), '0);
            expect_st(c0, 16'(1 << i), 2);
        end
    endtask

    task t_report;
        c0 = lnk.st_cnt;
        pulse(4'h4, {1'b1, 4'h5, 8'ha7});
        expect_st(c0, 16'ha754, 8);
    endtask

    task t_selfid;
        c0 = lnk.st_cnt;
        @(posedge aclk);
        node_id_reg <= 8'h3c;
        selfid_done <= 1'b1;
        @(posedge aclk);
        selfid_done <= 1'b0;
        expect_st(c0, {8'h3c, plsr_pkg::NODE_ID_REG_ADDR, 4'h0}, 8);
    endtask

    task t_swreq;
        c0 = lnk.st_cnt;
        axw(plsr_pkg::OFS_REGREQ, 32'h0000_5a09);
        expect_st(c0, 16'h5a90, 8);
    endtask

    task t_disable;
        axw(plsr_pkg::OFS_CTRL, 32'h0);
        c0 = lnk.st_cnt;
        pulse(4'h8, '0);
        repeat (20) @(negedge aclk);
        cmp(lnk.st_cnt, c0);
        axr(plsr_pkg::OFS_STATUS);
        cmp(rd[3:0], 4'h8);
        axw(plsr_pkg::OFS_CTRL, 32'h1);
        expect_st(c0, 16'h0008, 2);
    endtask

    task t_rx;
        for (int s = 0; s < 4; s++) do_rx(s, s + 1);
        do_rx(0, 0);
        axr(plsr_pkg::OFS_RXCOUNT);
        cmp(rd, 32'h5);
    endtask

    task t_abort;
        c0 = lnk.st_cnt;
        pulse(4'h1, {1'b1, 4'h6, 8'h81});
        repeat (20) begin
            @(negedge aclk);
            if (ctl == plsr_pkg::CTL_STATUS) break;
        end
        @(negedge aclk);
        do_rx(2, 2);
        cmp(lnk.st_cnt, c0 + 1);
        cmp(lnk.st_pairs < 8, 1);
        expect_st(c0 + 1, 16'h8160, 8);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            test_done;
        end
    end

    initial begin
        code_tab = '{plsr_pkg::CODE_LOW, plsr_pkg::CODE_MID,
                     plsr_pkg::CODE_HIGH, plsr_pkg::CODE_HIGH};
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, node_id_reg, selfid_done} = '0;
        wstrb = 4'hf;
        evt = '0;
        rx = '0;
        reg_read = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        t_reset;
        t_flags;
        t_report;
        t_selfid;
        t_swreq;
        t_disable;
        t_rx;
        t_abort;
        cmp(lnk.viol, 0);
        test_done;
    end
endmodule // tb_top
